// ===== logic/tx_cfg_pkg.sv
/*
 * Shared constants for the transmit configuration store: register map,
 * field positions, stored default image and timing counts.
 * Assumes a 20 MHz pclk.
 */
package tx_cfg_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int NS_PER_S = 1_000_000_000;
    localparam int CLK_PERIOD_NS = NS_PER_S / CLK_HZ;
    localparam int RAMP_UNIT_NS = 1_000;
    localparam int RAMP_UNIT_CYCLES = RAMP_UNIT_NS / CLK_PERIOD_NS;
    localparam int RAMP_MAX_US = 1024;
    localparam int RAMP_FULL_DEF = RAMP_MAX_US * RAMP_UNIT_CYCLES;
    localparam int STOP_UNIT_NS = 1_000_000;
    localparam int STOP_UNIT_DEF = STOP_UNIT_NS / CLK_PERIOD_NS;

    localparam logic [7:0] OFS_FREQ = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_LEVEL = 8'h08;
    localparam logic [7:0] OFS_RATE = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    localparam int MODE_LSB = 0;
    localparam int REP_BIT = 2;
    localparam int START_BIT = 3;
    localparam int RAMP_LSB = 4;
    localparam int STOP_LSB = 8;
    localparam int DEV_LSB = 0;
    localparam int POWER_LSB = 8;

    localparam logic [1:0] MOD_FSK = 2'h0;
    localparam logic [1:0] MOD_GFSK = 2'h1;
    localparam logic [1:0] MOD_OOK = 2'h2;

    localparam logic [19:0] FREQ_MIN = 20'h3A980;
    localparam logic [19:0] FREQ_MAX = 20'hEA600;
    localparam logic [7:0] DEV_MIN = 8'h01;
    localparam logic [7:0] DEV_MAX = 8'h64;
    localparam logic signed [4:0] POWER_MIN = -5'sd10;
    localparam logic signed [4:0] POWER_MAX = 5'sd13;
    localparam logic [3:0] RAMP_SEL_MAX = 4'hB;
    localparam logic [14:0] RAMP_STEP_MAX = 15'h0400;

    localparam int NVM_WORDS = 4;
    localparam logic [31:0] NVM_FREQ = 32'h000D_3FFE;
    localparam logic [31:0] NVM_MODE = 32'h0000_0800;
    localparam logic [31:0] NVM_LEVEL = 32'h0000_0D23;
    localparam logic [31:0] NVM_RATE = 32'h0000_0018;
endpackage : tx_cfg_pkg

// ===== logic/pa_ramp.sv
/*
 * Amplifier level ramp: moves a level toward zero or full scale by a
 * fixed step each clock. Same step both ways, so rise and fall match.
 * Assumes step and target come from flops on pclk.
 */
`timescale 1ns/10ps
module pa_ramp #(
    parameter logic [14:0] FULL = 15'h5000
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        target_on,
    input  wire logic [14:0] step,
    output logic      [14:0] level_reg
);
    logic [15:0] up_sum;
    logic [14:0] level_next;

    // RULE8 RULE17 same step, monotonic
    always_comb begin
        up_sum = {1'b0, level_reg} + {1'b0, step};
        if (target_on) begin
            level_next = (up_sum >= {1'b0, FULL}) ? FULL : up_sum[14:0];
        end else begin
            level_next = (level_reg <= step) ? 15'h0000 : level_reg - step;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_reg <= 15'h0000;
        end else begin
            level_reg <= level_next;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ramp_rise_mono: assert property ( // RULE17
        target_on && $past(target_on) |-> level_reg >= $past(level_reg))
        else $error("level fell while ramping up");
    a_ramp_same_step: assert property ( // RULE8
        $stable(step) && level_reg != 15'h0000 && level_reg != FULL
        && $past(level_reg) != 15'h0000 && $past(level_reg) != FULL
        |-> (level_reg - $past(level_reg) == step)
            || ($past(level_reg) - level_reg == step))
        else $error("ramp step differs between directions");
endmodule : pa_ramp

// ===== logic/tx_config.sv
/*
 * Transmit configuration store with APB register access, power-up
 * copy from the stored image, start/stop detection on the data pin and
 * amplifier ramp control.
 * Assumes pclk at 20 MHz; data_pin is asynchronous to pclk.
 */
// Register access over APB and the register addresses were chosen for this implementation.
// Operation
// RULE1: every reset copies the stored image into the working registers.
// RULE2: working registers hold until software rewrites any or all of them.
// RULE3: written values are volatile; reset restores stored defaults.
// RULE4: the host configures the device through its register port.
// RULE5: ramp setting picks 0 or 1 to 1024 us in powers of two.
// RULE6: ramp applies only in on-off keying; shift modes ignore it.
// RULE7: ramp setting zero reaches full level as fast as possible.
// RULE8: ramp down lasts exactly as long as ramp up.
// RULE9: start setting picks rising or falling data edge, rising default.
// RULE10: data held low for 2 to 90 ms ends transmit, 20 ms default.
// RULE11: data mapping picks which bit uses upper frequency, 1 default.
// RULE12: modulation is shift, Gaussian shift or on-off keying, shift default.
// RULE13: carrier 240 to 960 MHz in 1 kHz steps, 868.35 MHz default.
// RULE14: output power spans -10 to +13 dBm in 1 dB steps.
// RULE15: deviation 1 to 100 kHz default 35; symbol rate default 2.4 ksps.
// RULE16: user keeps ramp at most half a symbol period.
// RULE17: on-off keying ramps each turn-on and turn-off monotonically.

`timescale 1ns/10ps
module tx_config #(
    parameter int STOP_UNIT = tx_cfg_pkg::STOP_UNIT_DEF,
    parameter logic [14:0] RAMP_FULL = 15'(tx_cfg_pkg::RAMP_FULL_DEF)
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        data_pin,
    output logic             tx_active,
    output logic             shift_high,
    output logic      [14:0] pa_level,
    output logic      [19:0] carrier_khz,
    output logic      [1:0]  modulation,
    output logic      [7:0]  deviation_khz,
    output logic      [4:0]  pa_power,
    output logic      [15:0] symbol_rate_setting
);
    import tx_cfg_pkg::*;

    localparam logic [31:0] NVM_IMAGE [NVM_WORDS] =
        '{NVM_FREQ, NVM_MODE, NVM_LEVEL, NVM_RATE};

    logic [19:0] freq_reg;
    logic [11:0] mode_reg;
    logic [12:0] level_reg;
    logic [15:0] rate_reg;
    logic [2:0]  load_idx_reg;
    logic        load_done_reg;
    logic        ready_reg;
    logic        err_reg;
    logic [31:0] rdata_reg;
    logic        data_meta_reg;
    logic        data_sync_reg;
    logic        data_prev_reg;
    logic        tx_reg;
    logic        shift_reg;
    logic [14:0] cyc_cnt_reg;
    logic [6:0]  ms_cnt_reg;
    logic [14:0] step_reg;
    logic        target_reg;
    logic        wr_en;
    logic        acc;
    logic        addr_ok;
    logic [31:0] wr_word;
    logic [6:0]  stop_ms;
    logic        start_edge;
    logic [1:0]  wr_mode;
    logic [3:0]  wr_ramp;
    logic [19:0] wr_freq;
    logic [7:0]  wr_dev;
    logic signed [4:0] wr_pow;

    assign acc = psel && penable;
    assign wr_en = acc && ready_reg && pwrite && addr_ok
                   && paddr != OFS_STATUS;
    assign addr_ok = paddr == OFS_FREQ || paddr == OFS_MODE
                     || paddr == OFS_LEVEL || paddr == OFS_RATE
                     || paddr == OFS_STATUS;

    // RULE13 RULE14 RULE15 clamp written values
    always_comb begin
        wr_word = load_done_reg ? pwdata : NVM_IMAGE[load_idx_reg[1:0]];
        wr_freq = wr_word[19:0];
        if (wr_freq < FREQ_MIN) wr_freq = FREQ_MIN;
        if (wr_freq > FREQ_MAX) wr_freq = FREQ_MAX;
        wr_mode = wr_word[MODE_LSB +: 2];
        // RULE12 reserved code falls back to shift keying
        if (wr_mode == 2'h3) wr_mode = MOD_FSK;
        // RULE5 twelve ramp choices
        wr_ramp = wr_word[RAMP_LSB +: 4];
        if (wr_ramp > RAMP_SEL_MAX) wr_ramp = RAMP_SEL_MAX;
        wr_dev = wr_word[DEV_LSB +: 8];
        if (wr_dev < DEV_MIN) wr_dev = DEV_MIN;
        if (wr_dev > DEV_MAX) wr_dev = DEV_MAX;
        wr_pow = signed'(wr_word[POWER_LSB +: 5]);
        if (wr_pow < POWER_MIN) wr_pow = POWER_MIN;
        if (wr_pow > POWER_MAX) wr_pow = POWER_MAX;
    end

    // RULE1 RULE3 copy stored image after every reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_idx_reg <= 3'h0;
            load_done_reg <= 1'b0;
        end else if (!load_done_reg) begin
            load_idx_reg <= load_idx_reg + 3'h1;
            load_done_reg <= load_idx_reg == 3'(NVM_WORDS - 1);
        end
    end

    // RULE2 hold until rewritten
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_reg <= 20'h00000;
            mode_reg <= 12'h000;
            level_reg <= 13'h0000;
            rate_reg <= 16'h0000;
        end else if (!load_done_reg || wr_en) begin
            unique case (load_done_reg ? paddr
                         : {4'h0, load_idx_reg[1:0], 2'h0})
                OFS_FREQ: freq_reg <= wr_freq;
                OFS_MODE: mode_reg <= {wr_word[STOP_LSB +: 4], wr_ramp,
                                       wr_word[START_BIT], wr_word[REP_BIT],
                                       wr_mode};
                OFS_LEVEL: level_reg <= {wr_pow, wr_dev};
                OFS_RATE: rate_reg <= wr_word[15:0];
                default: ;
            endcase
        end
    end

    // One wait state; pready held low until the copy completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ready_reg <= acc && !ready_reg && load_done_reg;
            err_reg <= acc && !ready_reg && load_done_reg && !addr_ok;
            rdata_reg <= 32'h0000_0000;
            if (acc && !ready_reg && !pwrite) begin
                unique case (paddr)
                    OFS_FREQ: rdata_reg <= {12'h000, freq_reg};
                    OFS_MODE: rdata_reg <= {20'h00000, mode_reg};
                    OFS_LEVEL: rdata_reg <= {19'h00000, level_reg};
                    OFS_RATE: rdata_reg <= {16'h0000, rate_reg};
                    OFS_STATUS: rdata_reg <= {28'h0000000, data_sync_reg,
                                              target_reg, tx_reg,
                                              load_done_reg};
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_meta_reg <= 1'b0;
            data_sync_reg <= 1'b0;
            data_prev_reg <= 1'b0;
        end else begin
            data_meta_reg <= data_pin;
            data_sync_reg <= data_meta_reg;
            data_prev_reg <= data_sync_reg;
        end
    end

    // RULE9 selectable start edge
    assign start_edge = mode_reg[START_BIT]
                        ? (data_prev_reg && !data_sync_reg)
                        : (!data_prev_reg && data_sync_reg);

    // RULE10 codes 0..7 give 2..9 ms, 8..15 give 20..90 ms
    always_comb begin
        if (mode_reg[STOP_LSB + 3]) begin
            stop_ms = 7'(({4'h0, mode_reg[STOP_LSB +: 3]} + 7'h2) * 7'hA);
        end else begin
            stop_ms = {4'h0, mode_reg[STOP_LSB +: 3]} + 7'h2;
        end
    end

    // RULE10 low-time counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_cnt_reg <= 15'h0000;
            ms_cnt_reg <= 7'h00;
        end else if (!tx_reg || data_sync_reg) begin
            cyc_cnt_reg <= 15'h0000;
            ms_cnt_reg <= 7'h00;
        end else if (cyc_cnt_reg == 15'(STOP_UNIT - 1)) begin
            cyc_cnt_reg <= 15'h0000;
            ms_cnt_reg <= ms_cnt_reg + 7'h01;
        end else begin
            cyc_cnt_reg <= cyc_cnt_reg + 15'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_reg <= 1'b0;
        end else if (!tx_reg) begin
            tx_reg <= load_done_reg && start_edge;
        end else if (ms_cnt_reg >= stop_ms) begin
            tx_reg <= 1'b0;
        end
    end

    // RULE11 bit-to-frequency mapping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg <= 1'b0;
        end else begin
            shift_reg <= tx_reg && (data_sync_reg ^ mode_reg[REP_BIT]);
        end
    end

    // RULE6 RULE7 ramp only for on-off keying with nonzero setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_reg <= 15'h0000;
            target_reg <= 1'b0;
        end else begin
            if (mode_reg[MODE_LSB +: 2] == MOD_OOK
                && mode_reg[RAMP_LSB +: 4] != 4'h0) begin
                step_reg <= RAMP_STEP_MAX
                            >> (mode_reg[RAMP_LSB +: 4] - 4'h1);
            end else begin
                step_reg <= RAMP_FULL;
            end
            // RULE17 in on-off keying the amplifier follows the data level while transmitting
            target_reg <= tx_reg && (mode_reg[MODE_LSB +: 2] != MOD_OOK
                                     || data_sync_reg);
        end
    end

    pa_ramp #(
        .FULL(RAMP_FULL)
    ) u_ramp (
        .pclk     (pclk),
        .presetn  (presetn),
        .target_on(target_reg),
        .step     (step_reg),
        .level_reg(pa_level)
    );

    assign prdata = rdata_reg;
    assign pready = ready_reg;
    assign pslverr = err_reg;
    assign tx_active = tx_reg;
    assign shift_high = shift_reg;
    assign carrier_khz = freq_reg;
    assign modulation = mode_reg[MODE_LSB +: 2];
    assign deviation_khz = level_reg[DEV_LSB +: 8];
    assign pa_power = level_reg[POWER_LSB +: 5];
    assign symbol_rate_setting = rate_reg;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_load_bounded: assert property ( // RULE1
        !load_done_reg |-> ##[1:4] load_done_reg)
        else $error("stored image copy too slow");
    a_load_image: assert property ( // RULE1
        $rose(load_done_reg) |-> freq_reg == NVM_FREQ[19:0]
        && mode_reg == NVM_MODE[11:0] && rate_reg == NVM_RATE[15:0])
        else $error("working registers differ from stored image");
    a_hold_value: assert property ( // RULE2
        load_done_reg && $past(load_done_reg) && !$past(wr_en)
        |-> $stable(freq_reg) && $stable(mode_reg) && $stable(level_reg))
        else $error("register changed without a write");
    a_start_edge: assert property ( // RULE9
        !tx_reg && load_done_reg && start_edge |=> tx_reg)
        else $error("start edge missed");
    a_stop_time: assert property ( // RULE10
        $fell(tx_reg) |-> $past(ms_cnt_reg) == $past(stop_ms)
        && !$past(data_sync_reg))
        else $error("transmit ended at wrong low time");
    a_bit_mapping: assert property ( // RULE11
        tx_reg |=> shift_reg == ($past(data_sync_reg) ^ $past(mode_reg[2])))
        else $error("wrong frequency mapping");
    a_mode_legal: assert property ( // RULE12
        modulation != 2'h3)
        else $error("illegal modulation code");
    a_power_range: assert property ( // RULE14
        signed'(pa_power) >= POWER_MIN && signed'(pa_power) <= POWER_MAX)
        else $error("power setting out of range");
    a_fsk_no_ramp: assert property ( // RULE6
        modulation != MOD_OOK && $stable(mode_reg) && $rose(target_reg)
        && $past(step_reg) == RAMP_FULL |=> pa_level == RAMP_FULL)
        else $error("shift keying amplifier ramped");
    a_zero_ramp: assert property ( // RULE7
        mode_reg[7:4] == 4'h0 && $past(mode_reg[7:4]) == 4'h0
        && $past(mode_reg[7:4], 2) == 4'h0 && target_reg
        |=> pa_level == RAMP_FULL)
        else $error("zero ramp not immediate");
endmodule : tx_config

// ===== tb/host_model.sv
/*
 * Host model: APB master for the register port and driver of the data pin.
 * Assumes a free-running pclk and a slave that ends each access with pready.
 */
`timescale 1ns/10ps
module host_model (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    output logic             data_pin
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        data_pin = 1'b0;
    end

    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~wd;
        // Return where outputs have settled after the write edge
        @(negedge pclk);
    endtask : xfer

    // caller holds each level at least until the ramp completes
    task automatic drive(input logic v);
        @(posedge pclk);
        data_pin <= v;
    endtask : drive
endmodule : host_model

// ===== tb/test_tx_config_and_pa_ramp.sv
/*
 * Self-checking bench for the transmit configuration store.
 * Assumes the design package, design and host model compile first.
 */
`timescale 1ns/10ps
module test_tx_config_and_pa_ramp;
    import tx_cfg_pkg::*;
    localparam int          SU   = 20;
    localparam logic [14:0] FULL = 15'h0800;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        data_pin, err, tx_active, shift_high, mono;
    logic [7:0]  paddr, deviation_khz;
    logic [31:0] pwdata, prdata, rd;
    logic [14:0] pa_level;
    logic [19:0] carrier_khz;
    logic [1:0]  modulation;
    logic [4:0]  pa_power;
    logic [15:0] symbol_rate_setting;
    logic [31:0] m [4];
    int          fails, samples_checked, cycles, c;

    tx_config #(.STOP_UNIT(SU), .RAMP_FULL(FULL)) i_tx_config (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .data_pin(data_pin),
        .tx_active(tx_active), .shift_high(shift_high),
        .pa_level(pa_level), .carrier_khz(carrier_khz),
        .modulation(modulation), .deviation_khz(deviation_khz),
        .pa_power(pa_power), .symbol_rate_setting(symbol_rate_setting));
    host_model i_host_model (
        .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .data_pin(data_pin));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Hang guard, well above the longest expected run
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int p;
        i_host_model.xfer(1'b1, a, v, rd, err);
        p = $signed(v[12:8]);
        case (a)
            OFS_FREQ: m[0] = 32'(v[19:0] < FREQ_MIN ? FREQ_MIN :
                                 v[19:0] > FREQ_MAX ? FREQ_MAX : v[19:0]);
            OFS_MODE: m[1] = {20'h0, v[11:8],
                              v[7:4] > RAMP_SEL_MAX ? RAMP_SEL_MAX : v[7:4],
                              v[3:2], v[1:0] == 2'h3 ? MOD_FSK : v[1:0]};
            OFS_LEVEL: m[2] = {19'h0, 5'(p < -10 ? -10 : p > 13 ? 13 : p),
                               v[7:0] < DEV_MIN ? DEV_MIN :
                               v[7:0] > DEV_MAX ? DEV_MAX : v[7:0]};
            OFS_RATE: m[3] = {16'h0, v[15:0]};
            default: ;
        endcase
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        i_host_model.xfer(1'b0, a, $urandom, rd, err);
        check("read data", exp, rd);
        check("slave error", 32'(a > OFS_STATUS), 32'(err));
    endtask : rd_chk

    task automatic cfg_chk();
        for (int i = 0; i < 4; i++) rd_chk(8'(4 * i), m[i]);
        check("carrier", m[0], 32'(carrier_khz));
        check("deviation", 32'(m[2][7:0]), 32'(deviation_khz));
        check("power", 32'(m[2][12:8]), 32'(pa_power));
        check("rate", 32'(m[3][15:0]), 32'(symbol_rate_setting));
    endtask : cfg_chk

    task automatic wait_tx(input logic v);
        int k;
        k = 0;
        while (tx_active !== v && k < 200) begin
            @(posedge pclk);
            k++;
        end
        check("transmit active", 32'(v), 32'(tx_active));
    endtask : wait_tx

    // Counts distinct levels strictly between the ends, plus the last step
    task automatic ramp(input logic up, output int n);
        logic [14:0] prev;
        int k;
        n = 1;
        k = 0;
        prev = pa_level;
        while (k < 6000 && pa_level !== (up ? FULL : 15'h0)) begin
            @(posedge pclk);
            k++;
            if (pa_level !== 15'h0 && pa_level !== FULL) n++;
            if (up ? pa_level < prev : pa_level > prev) mono = 1'b0;
            prev = pa_level;
        end
    endtask : ramp

    task automatic load_defaults();
        m[0] = 32'h000D_3FFE;
        m[1] = 32'h0000_0800;
        m[2] = {19'h0, 5'h0D, 8'h23};
        m[3] = 32'h0000_0018;
    endtask : load_defaults

    initial begin
        presetn = 1'b0;
        mono = 1'b1;
        void'($urandom(98));
        load_defaults();
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        cfg_chk();
        wr(OFS_STATUS, $urandom);
        rd_chk(OFS_STATUS, 32'h1);
        wr(8'h20, $urandom);
        check("unmapped error", 32'h1, 32'(err));
        rd_chk(8'h14, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(OFS_FREQ, $urandom);
            if (i[0]) wr(OFS_LEVEL, $urandom);
            if (i[1]) wr(OFS_RATE, $urandom);
            cfg_chk();
        end
        wr(OFS_LEVEL, 32'h0000_14C8);
        wr(OFS_FREQ, 32'h0);
        cfg_chk();
        for (int i = 0; i < 4; i++) begin
            wr(OFS_MODE, 32'(i));
            check("modulation", 32'(i == 3 ? 0 : i), 32'(modulation));
            rd_chk(OFS_MODE, m[1]);
        end
        for (int s = 0; s < 16; s++) begin
            wr(OFS_MODE, 32'(s << 8 | (s & 1) << 2));
            i_host_model.drive(1'b1);
            wait_tx(1'b1);
            repeat (4) @(posedge pclk);
            check("upper shift", 32'(~s & 1), 32'(shift_high));
            check("shift level", 32'(FULL), 32'(pa_level));
            i_host_model.drive(1'b0);
            c = 0;
            while (tx_active === 1'b1 && c < 2000) begin
                @(posedge pclk);
                c++;
                if (c == 5)
                    check("lower shift", 32'(s & 1), 32'(shift_high));
            end
            c -= (s < 8 ? s + 2 : 20 + 10 * (s - 8)) * SU;
            check("stop time", 32'h1, 32'(c >= 0 && c <= 6));
        end
        wr(OFS_MODE, 32'h0000_0008);
        i_host_model.drive(1'b1);
        repeat (10) @(posedge pclk);
        check("rise ignored", 32'h0, 32'(tx_active));
        i_host_model.drive(1'b0);
        wait_tx(1'b1);
        wait_tx(1'b0);
        i_host_model.drive(1'b1);
        wr(OFS_MODE, 32'h0);
        i_host_model.drive(1'b0);
        // Settings 12 and 13 put the longest ramp on the shift modes
        for (int n = 0; n < 14; n++) begin
            wr(OFS_MODE, 32'(n < 12 ? n << 4 | 2 : 11 << 4 | n - 12));
            i_host_model.drive(1'b1);
            ramp(1'b1, c);
            check("ramp up", 32'(n == 0 || n > 11 ? 1 :
                  int'(FULL) / (1024 >> (n - 1))), 32'(c));
            i_host_model.drive(1'b0);
            ramp(1'b0, c);
            check("ramp down", 32'(n == 0 || n > 11 ? 1 :
                  int'(FULL) / (1024 >> (n - 1))), 32'(c));
            wait_tx(1'b0);
        end
        check("monotonic ramp", 32'h1, 32'(mono));
        wr(OFS_FREQ, 32'h000A_0000);
        check("carrier", m[0], 32'(carrier_khz));
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        load_defaults();
        cfg_chk();
        tally_and_finish();
    end
endmodule : test_tx_config_and_pa_ramp
